// *** rtl/cid_decoder.sv ***
// 8-bit instruction decoder with accumulator, flags and apb registers
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "cid_defines.svh"
// Operation
// - instructions are one to three bytes, fed in order; data is 8 bits
// - register fields: B C D E H L, memory at HL, accumulator
// - register copy takes 5 cycles without memory
// - copies to or from memory via HL take 7 cycles
// - immediate byte load: 7 cycles, 10 into memory
// - 8-bit increment/decrement: 5 cycles, 10 on memory
// - eight accumulator ops with register source: 4 cycles, memory 7
// - same eight ops with immediate second byte: 7 cycles
// - four accumulator rotates, 4 cycles each
// - call 17 cycles; conditional call 11 not taken, 17 taken
// - exit 10 cycles; conditional exit 5 not taken, 11 taken
// - restart acts as vector call, 11 cycles
// - port input and output are two bytes, 10 cycles
// - pair immediate load 10 cycles, pp selects BC DE HL SP
// - push 11, pop 10; pp 11 means accumulator with flags
// - direct accumulator store/load 13, HL store/load 16 cycles
// - indirect accumulator store/load via BC or DE, 7 cycles
// - pair step 5 cycles, double add 10 cycles
// - swap DE/HL 4, stack top/HL 18, HL to SP or PC 5
// - complement, carry ops, decimal adjust, enables, no-op: 4 cycles
// - interrupt at instruction end replaces next instruction
module cid_decoder
  import cid_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt pins
  input wire logic int_req,
  output logic int_ack,
  // sequencing status
  output logic halted,
  output logic insn_done
);

  cid_seq_t seq_q;
  cid_cls_t cls_q;
  cid_cls_t d_cls;
  logic [7:0] op_q, b2_q, b3_q, acc_q, opnd_q, dbyte, acc_d;
  logic [4:0] flg_q, flg_d, cyc_q, d_cyc, cyc_fin;
  logic [1:0] len_q, d_len;
  logic taken_q, halted_q, ie_q, int_ack_q, done_q;
  logic int_s1, int_s2, int_take;
  logic wr_en, byte_wr, last, complete, cond_ok, addr_ok;
  logic [31:0] rd_mux, prdata_q;

  assign wr_en = psel & penable & pwrite;
  assign byte_wr = wr_en & (paddr == `CID_OFF_BYTE) & pstrb[0];
  // the opcode decodes from the bus while it is being written
  assign dbyte = (seq_q == seq_opcode) ? pwdata[7:0] : op_q;

  // opcode decode
  always_comb
  begin
    d_cls = c_no_operation;
    d_len = 2'd1;
    d_cyc = `CID_CYC_T4;
    casez (dbyte)
      8'b01110110:
      begin
        d_cls = c_halt_processor;
        d_cyc = `CID_CYC_T7;
      end
      8'b01??????:
      begin
        d_cls = c_copy_register;
        d_cyc = (dbyte[5:3] == `CID_SEL_MEM || dbyte[2:0] == `CID_SEL_MEM)
          ? `CID_CYC_T7 : `CID_CYC_T5;
      end
      8'b00???110:
      begin
        d_cls = c_load_immediate_8;
        d_len = 2'd2;
        d_cyc = (dbyte[5:3] == `CID_SEL_MEM) ? `CID_CYC_T10
          : `CID_CYC_T7;
      end
      8'b00???10?:
      begin
        d_cls = dbyte[0] ? c_decrement_8 : c_increment_8;
        d_cyc = (dbyte[5:3] == `CID_SEL_MEM) ? `CID_CYC_T10
          : `CID_CYC_T5;
      end
      8'b10??????:
      begin
        d_cls = c_acc_op;
        d_cyc = (dbyte[2:0] == `CID_SEL_MEM) ? `CID_CYC_T7
          : `CID_CYC_T4;
      end
      8'b11???110:
      begin
        d_cls = c_acc_op_immediate;
        d_len = 2'd2;
        d_cyc = `CID_CYC_T7;
      end
      8'b000??111: d_cls = c_rotate;
      8'b001??111: d_cls = c_flag_acc_misc;
      8'b11000011:
      begin
        d_cls = c_branch_always;
        d_len = 2'd3;
        d_cyc = `CID_CYC_T10;
      end
      8'b11???010:
      begin
        d_cls = c_branch_cond;
        d_len = 2'd3;
        d_cyc = `CID_CYC_T10;
      end
      8'b11001101:
      begin
        d_cls = c_call;
        d_len = 2'd3;
        d_cyc = `CID_CYC_T17;
      end
      8'b11???100:
      begin
        d_cls = c_call_cond;
        d_len = 2'd3;
        d_cyc = `CID_CYC_T11;
      end
      8'b11001001:
      begin
        d_cls = c_subroutine_exit;
        d_cyc = `CID_CYC_T10;
      end
      8'b11???000:
      begin
        d_cls = c_exit_cond;
        d_cyc = `CID_CYC_T5;
      end
      8'b11???111:
      begin
        d_cls = c_restart;
        d_cyc = `CID_CYC_T11;
      end
      8'b1101?011:
      begin
        d_cls = dbyte[3] ? c_port_in : c_port_out;
        d_len = 2'd2;
        d_cyc = `CID_CYC_T10;
      end
      8'b00??0001:
      begin
        d_cls = c_load_pair_immediate;
        d_len = 2'd3;
        d_cyc = `CID_CYC_T10;
      end
      8'b11??0101:
      begin
        d_cls = c_push;
        d_cyc = `CID_CYC_T11;
      end
      8'b11??0001:
      begin
        d_cls = c_pop;
        d_cyc = `CID_CYC_T10;
      end
      8'b001??010:
      begin
        d_cls = c_direct;
        d_len = 2'd3;
        d_cyc = dbyte[4] ? `CID_CYC_T13 : `CID_CYC_T16;
      end
      8'b000??010:
      begin
        d_cls = c_indirect;
        d_cyc = `CID_CYC_T7;
      end
      8'b00???011:
      begin
        d_cls = c_pair_step;
        d_cyc = `CID_CYC_T5;
      end
      8'b00??1001:
      begin
        d_cls = c_double_add;
        d_cyc = `CID_CYC_T10;
      end
      8'b11101011: d_cls = c_swap_de_hl;
      8'b11100011:
      begin
        d_cls = c_swap_stack_top_hl;
        d_cyc = `CID_CYC_T18;
      end
      8'b11111001:
      begin
        d_cls = c_hl_to_stack_pointer;
        d_cyc = `CID_CYC_T5;
      end
      8'b11101001:
      begin
        d_cls = c_hl_to_program_counter;
        d_cyc = `CID_CYC_T5;
      end
      8'b11111011: d_cls = c_interrupts_on;
      8'b11110011: d_cls = c_interrupts_off;
      default: d_cls = c_no_operation;
    endcase
  end

  // flag tests for conditional branches, calls and exits
  always_comb
  begin
    case (dbyte[5:3])
      3'h0: cond_ok = ~flg_q[`CID_FLG_ZR];
      3'h1: cond_ok = flg_q[`CID_FLG_ZR];
      3'h2: cond_ok = ~flg_q[`CID_FLG_CY];
      3'h3: cond_ok = flg_q[`CID_FLG_CY];
      3'h4: cond_ok = ~flg_q[`CID_FLG_PAR];
      3'h5: cond_ok = flg_q[`CID_FLG_PAR];
      3'h6: cond_ok = ~flg_q[`CID_FLG_SG];
      default: cond_ok = flg_q[`CID_FLG_SG];
    endcase
  end

  always_comb
  begin
    case (d_cls)
      c_call_cond: cyc_fin = cond_ok ? `CID_CYC_T17 : `CID_CYC_T11;
      c_exit_cond: cyc_fin = cond_ok ? `CID_CYC_T11 : `CID_CYC_T5;
      default: cyc_fin = d_cyc;
    endcase
  end

  // byte sequencing: later bytes follow the opcode in order
  assign last = (seq_q == seq_opcode && d_len == 2'd1)
    || (seq_q == seq_byte2 && d_len == 2'd2) || (seq_q == seq_byte3);
  // bytes offered while halted are dropped
  assign complete = byte_wr & ~halted_q & last;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seq_q <= seq_opcode;
    else if (byte_wr && !halted_q)
    begin
      case (seq_q)
        seq_opcode: seq_q <= last ? seq_opcode : seq_byte2;
        seq_byte2: seq_q <= last ? seq_opcode : seq_byte3;
        seq_byte3: seq_q <= seq_opcode;
        default: seq_q <= seq_opcode;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_q <= 8'h00;
      b2_q <= 8'h00;
      b3_q <= 8'h00;
    end
    else if (byte_wr && !halted_q)
    begin
      if (seq_q == seq_opcode)
        op_q <= pwdata[7:0];
      if (seq_q == seq_byte2)
        b2_q <= pwdata[7:0];
      if (seq_q == seq_byte3)
        b3_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cls_q <= c_no_operation;
      len_q <= 2'd1;
      cyc_q <= `CID_CYC_T4;
      taken_q <= 1'b0;
    end
    else if (complete)
    begin
      cls_q <= d_cls;
      len_q <= d_len;
      cyc_q <= cyc_fin;
      taken_q <= cond_ok;
    end
  end

  // accumulator and flag effects
  logic [7:0] opa, opb, res, incx;
  logic [8:0] sum;
  logic [4:0] nib;
  logic sub, cin, is_acc_dst, lo_adj, hi_adj;

  always_comb
  begin
    acc_d = acc_q;
    flg_d = flg_q;
    res = 8'h00;
    opa = acc_q;
    is_acc_dst = (dbyte[5:3] == `CID_SEL_ACC);
    opb = (dbyte[2:0] == `CID_SEL_ACC) ? acc_q : opnd_q;
    if (d_cls == c_acc_op_immediate || d_cls == c_load_immediate_8)
      opb = pwdata[7:0];
    // only sub, borrow-sub and compare invert; or shares bit 4
    sub = dbyte[4] & ~(dbyte[5] & ~dbyte[3])
      & (d_cls == c_acc_op || d_cls == c_acc_op_immediate);
    // carry enters only for the two carry ops, never for compare
    cin = (dbyte[3] & ~dbyte[5] & flg_q[`CID_FLG_CY]) ^ sub;
    if (sub)
      opb = ~opb;
    sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    incx = is_acc_dst ? acc_q : opnd_q;
    lo_adj = (acc_q[3:0] > 4'h9) | flg_q[`CID_FLG_AC];
    hi_adj = (acc_q > 8'h99) | flg_q[`CID_FLG_CY];
    case (d_cls)
      c_copy_register:
        if (is_acc_dst)
          acc_d = opb;
      c_load_immediate_8:
        if (is_acc_dst)
          acc_d = opb;
      c_acc_op, c_acc_op_immediate:
      begin
        case (cid_aluop_t'(dbyte[5:3]))
          op_bitwise_and_acc:
          begin
            res = acc_q & opb;
            flg_d[`CID_FLG_CY] = 1'b0;
            flg_d[`CID_FLG_AC] = acc_q[3] | opb[3];
          end
          op_bitwise_xor_acc, op_bitwise_or_acc:
          begin
            res = dbyte[4] ? (acc_q | opb) : (acc_q ^ opb);
            flg_d[`CID_FLG_CY] = 1'b0;
            flg_d[`CID_FLG_AC] = 1'b0;
          end
          default:
          begin
            // subtraction adds the complement; carry reads as borrow
            res = sum[7:0];
            flg_d[`CID_FLG_CY] = sum[8] ^ sub;
            flg_d[`CID_FLG_AC] = nib[4];
          end
        endcase
        if (dbyte[5:3] != op_compare_acc)
          acc_d = res;
        flg_d[`CID_FLG_SG] = res[7];
        flg_d[`CID_FLG_ZR] = (res == 8'h00);
        flg_d[`CID_FLG_PAR] = ~^res;
      end
      c_increment_8, c_decrement_8:
      begin
        // carry is left alone by single-byte steps
        res = dbyte[0] ? (incx - 8'h01) : (incx + 8'h01);
        if (is_acc_dst)
          acc_d = res;
        flg_d[`CID_FLG_AC] = dbyte[0] ? (incx[3:0] != 4'h0)
          : (incx[3:0] == 4'hF);
        flg_d[`CID_FLG_SG] = res[7];
        flg_d[`CID_FLG_ZR] = (res == 8'h00);
        flg_d[`CID_FLG_PAR] = ~^res;
      end
      c_rotate:
      begin
        case (dbyte[4:3])
          2'h0: acc_d = {acc_q[6:0], acc_q[7]};
          2'h1: acc_d = {acc_q[0], acc_q[7:1]};
          2'h2: acc_d = {acc_q[6:0], flg_q[`CID_FLG_CY]};
          default: acc_d = {flg_q[`CID_FLG_CY], acc_q[7:1]};
        endcase
        flg_d[`CID_FLG_CY] = dbyte[3] ? acc_q[0] : acc_q[7];
      end
      c_flag_acc_misc:
      begin
        case (dbyte[4:3])
          2'h0:
          begin
            res = acc_q + (lo_adj ? 8'h06 : 8'h00);
            res = res + (hi_adj ? 8'h60 : 8'h00);
            acc_d = res;
            flg_d[`CID_FLG_CY] = hi_adj;
            flg_d[`CID_FLG_AC] = acc_q[3:0] > 4'h9;
            flg_d[`CID_FLG_SG] = res[7];
            flg_d[`CID_FLG_ZR] = (res == 8'h00);
            flg_d[`CID_FLG_PAR] = ~^res;
          end
          2'h1: acc_d = ~acc_q;
          2'h2: flg_d[`CID_FLG_CY] = 1'b1;
          default: flg_d[`CID_FLG_CY] = ~flg_q[`CID_FLG_CY];
        endcase
      end
      default: acc_d = acc_q;
    endcase
  end

  assign addr_ok = (paddr == `CID_OFF_BYTE) || (paddr == `CID_OFF_STAT)
    || (paddr == `CID_OFF_OPER) || (paddr == `CID_OFF_ACC)
    || (paddr == `CID_OFF_FLAG) || (paddr == `CID_OFF_OPND);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_q <= `CID_ACC_RST;
    else if (complete)
      acc_q <= acc_d;
    else if (wr_en && paddr == `CID_OFF_ACC && pstrb[0])
      acc_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flg_q <= `CID_FLG_RST;
    else if (complete)
      flg_q <= flg_d;
    else if (wr_en && paddr == `CID_OFF_FLAG && pstrb[0])
      flg_q <= pwdata[4:0];
  end

  // value of a register or memory source, loaded by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      opnd_q <= `CID_OPND_RST;
    else if (wr_en && paddr == `CID_OFF_OPND && pstrb[0])
      opnd_q <= pwdata[7:0];
  end

  // interrupt request arrives asynchronously
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_s1 <= 1'b0;
      int_s2 <= 1'b0;
    end
    else
    begin
      int_s1 <= int_req;
      int_s2 <= int_s1;
    end
  end

  // taken at the last byte or while halted, so the next opcode is the vector instruction
  assign int_take = ie_q & int_s2 & (complete | halted_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ie_q <= 1'b0;
    else if (int_take)
      ie_q <= 1'b0;
    else if (complete && d_cls == c_interrupts_on)
      ie_q <= 1'b1;
    else if (complete && d_cls == c_interrupts_off)
      ie_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halted_q <= 1'b0;
    else if (int_take)
      halted_q <= 1'b0;
    else if (complete && d_cls == c_halt_processor)
      halted_q <= 1'b1;
  end

  // set wins over the clear by the next opcode byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_ack_q <= 1'b0;
    else if (int_take)
      int_ack_q <= 1'b1;
    else if (byte_wr && seq_q == seq_opcode)
      int_ack_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_q <= 1'b0;
    else
      done_q <= complete;
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CID_OFF_BYTE: rd_mux[7:0] = op_q;
      `CID_OFF_STAT:
      begin
        rd_mux[`CID_ST_OPC_LSB +: 8] = op_q;
        rd_mux[`CID_ST_LEN_LSB +: 2] = len_q;
        rd_mux[`CID_ST_CYC_LSB +: 5] = cyc_q;
        rd_mux[`CID_ST_CLS_LSB +: 5] = cls_q;
        rd_mux[`CID_ST_TAKEN] = taken_q;
        rd_mux[`CID_ST_HALTED] = halted_q;
        rd_mux[`CID_ST_IE] = ie_q;
        rd_mux[`CID_ST_INTACK] = int_ack_q;
        rd_mux[`CID_ST_SEQ_LSB +: 2] = seq_q;
      end
      `CID_OFF_OPER:
      begin
        rd_mux[`CID_OP_B2_LSB +: 8] = b2_q;
        rd_mux[`CID_OP_B3_LSB +: 8] = b3_q;
        rd_mux[`CID_OP_DST_LSB +: 3] = op_q[5:3];
        rd_mux[`CID_OP_SRC_LSB +: 3] = op_q[2:0];
        rd_mux[`CID_OP_PAIR_LSB +: 2] = op_q[5:4];
      end
      `CID_OFF_ACC: rd_mux[7:0] = acc_q;
      `CID_OFF_FLAG: rd_mux[4:0] = flg_q;
      `CID_OFF_OPND: rd_mux[7:0] = opnd_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle, so it reads as a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= rd_mux;
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign int_ack = int_ack_q;
  assign halted = halted_q;
  assign insn_done = done_q;

endmodule // cid_decoder

// *** include/cid_defines.svh ***
// register offsets, field positions, reset values and cycle counts
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH
`define CID_OFF_BYTE 12'h000
`define CID_OFF_STAT 12'h004
`define CID_OFF_OPER 12'h008
`define CID_OFF_ACC 12'h00C
`define CID_OFF_FLAG 12'h010
`define CID_OFF_OPND 12'h014
`define CID_FLG_CY 0
`define CID_FLG_PAR 1
`define CID_FLG_AC 2
`define CID_FLG_ZR 3
`define CID_FLG_SG 4
`define CID_ST_OPC_LSB 0
`define CID_ST_LEN_LSB 8
`define CID_ST_CYC_LSB 10
`define CID_ST_CLS_LSB 15
`define CID_ST_TAKEN 20
`define CID_ST_HALTED 21
`define CID_ST_IE 22
`define CID_ST_INTACK 23
`define CID_ST_SEQ_LSB 24
`define CID_OP_B2_LSB 0
`define CID_OP_B3_LSB 8
`define CID_OP_DST_LSB 16
`define CID_OP_SRC_LSB 19
`define CID_OP_PAIR_LSB 22
`define CID_ACC_RST 8'h00
`define CID_FLG_RST 5'h00
`define CID_OPND_RST 8'h00
`define CID_SEL_MEM 3'h6
`define CID_SEL_ACC 3'h7
`define CID_CYC_T4 5'h04
`define CID_CYC_T5 5'h05
`define CID_CYC_T7 5'h07
`define CID_CYC_T10 5'h0A
`define CID_CYC_T11 5'h0B
`define CID_CYC_T13 5'h0D
`define CID_CYC_T16 5'h10
`define CID_CYC_T17 5'h11
`define CID_CYC_T18 5'h12
`endif

// *** include/cid_pkg.sv ***
// types shared by the instruction decoder
package cid_pkg;
  typedef enum logic [4:0] {
    c_no_operation = 5'h00, c_copy_register = 5'h01,
    c_halt_processor = 5'h02, c_load_immediate_8 = 5'h03,
    c_increment_8 = 5'h04, c_decrement_8 = 5'h05,
    c_acc_op = 5'h06, c_acc_op_immediate = 5'h07,
    c_rotate = 5'h08, c_branch_always = 5'h09,
    c_branch_cond = 5'h0A, c_call = 5'h0B, c_call_cond = 5'h0C,
    c_subroutine_exit = 5'h0D, c_exit_cond = 5'h0E,
    c_restart = 5'h0F, c_port_in = 5'h10, c_port_out = 5'h11,
    c_load_pair_immediate = 5'h12, c_push = 5'h13, c_pop = 5'h14,
    c_direct = 5'h15, c_indirect = 5'h16, c_pair_step = 5'h17,
    c_double_add = 5'h18, c_swap_de_hl = 5'h19,
    c_swap_stack_top_hl = 5'h1A, c_hl_to_stack_pointer = 5'h1B,
    c_hl_to_program_counter = 5'h1C, c_flag_acc_misc = 5'h1D,
    c_interrupts_on = 5'h1E, c_interrupts_off = 5'h1F
  } cid_cls_t;
  typedef enum logic [1:0] {
    seq_opcode = 2'h0, seq_byte2 = 2'h1, seq_byte3 = 2'h2
  } cid_seq_t;
  typedef enum logic [2:0] {
    op_add = 3'h0, op_add_carry = 3'h1, op_sub = 3'h2,
    op_difference_with_borrow = 3'h3, op_bitwise_and_acc = 3'h4,
    op_bitwise_xor_acc = 3'h5, op_bitwise_or_acc = 3'h6,
    op_compare_acc = 3'h7
  } cid_aluop_t;
endpackage

// *** testbench/cid_prog_mem.sv ***
// program memory stand-in supplying operand bytes in order
`timescale 1ns/10ps
module cid_prog_mem (
  // byte slot after the opcode
  input wire logic [1:0] idx,
  // byte stored in that slot
  output logic [7:0] data
);
  // a distinct value per slot, so swapped bytes show
  assign data = 8'h30 + {6'h00, idx} * 8'h11;
endmodule // cid_prog_mem

// *** testbench/cid_decoder_checker.sv ***
// port assertions for the instruction decoder
`timescale 1ns/10ps
module cid_decoder_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt and status
  input wire logic int_req,
  input wire logic int_ack,
  input wire logic halted,
  input wire logic insn_done
);
  wire byte_wr = psel && penable && pwrite && paddr == 12'h000 && pstrb[0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_halt_wr;
    halted && byte_wr;
  endsequence
  sequence s_req_held;
    $past(int_req) && $past(int_req, 2);
  endsequence
  property p_err_only;
    pslverr |-> psel && penable;
  endproperty
  a_err_only: assert property (p_err_only) else $error("stray error");
  property p_err_map;
    psel && penable && paddr > 12'h014 |-> pslverr;
  endproperty
  a_err_map: assert property (p_err_map) else $error("no error");
  property p_done_pulse;
    insn_done |=> !insn_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("long done");
  property p_done_src;
    insn_done |-> $past(byte_wr);
  endproperty
  a_done_src: assert property (p_done_src) else $error("done w/o byte");
  property p_drop;
    s_halt_wr |=> !insn_done;
  endproperty
  a_drop: assert property (p_drop) else $error("ran while halted");
  property p_halt_exit;
    $fell(halted) |-> int_ack;
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt left");
  property p_ack_rise;
    $rose(int_ack) |-> s_req_held;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("early ack");
  property p_ack_hold;
    int_ack && !byte_wr |=> int_ack;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped");
endmodule // cid_decoder_checker

bind cid_decoder cid_decoder_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .int_req(int_req), .int_ack(int_ack),
  .halted(halted), .insn_done(insn_done));

// *** testbench/tb.sv ***
// self-checking bench for the instruction decoder
`timescale 1ns/10ps
`include "cid_defines.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  logic pclk, presetn, psel, penable, pwrite, int_req, err, dn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [3:0] pstrb;
  logic pready, pslverr, int_ack, halted, insn_done;
  logic [1:0] idx;
  logic [7:0] pbyte;
  int fails = 0;
  int num_checks = 0;
  int cyc_n = 0;

  cid_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_req(int_req), .int_ack(int_ack), .halted(halted),
    .insn_done(insn_done));
  cid_prog_mem mem_u (.idx(idx), .data(pbyte));

  initial
  begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc_n++;
    if (cyc_n == 30000)
    begin
      fails++;
      stop_test();
    end
  end

  task stop_test;
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // request held until pready; idle cycle after each transfer
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    dn = insn_done;
  endtask

  task automatic feed(input logic [7:0] op, input int len);
    apb(1, `CID_OFF_BYTE, {24'h0, op});
    for (int i = 1; i < len; i++)
    begin
      `CHK("early done", 1'b0, dn)
      apb(0, `CID_OFF_STAT, 0);
      `CHK("seq", i[1:0], rd[25:24])
      idx <= i[1:0];
      @(posedge pclk);
      apb(1, `CID_OFF_BYTE, {24'h0, pbyte});
    end
    `CHK("done", 1'b1, dn)
    apb(0, `CID_OFF_STAT, 0);
    st = rd;
  endtask

  task automatic acc_op(input logic [7:0] op, input int len,
    input logic [7:0] a, input logic [4:0] f, input logic [7:0] x);
    apb(1, `CID_OFF_ACC, {24'h0, a});
    apb(1, `CID_OFF_FLAG, {27'h0, f});
    feed(op, len);
    apb(0, `CID_OFF_ACC, 0);
    `CHK("acc", x, rd[7:0])
  endtask

  // fields: opcode, length, cycles, class
  task automatic t_table;
    logic [27:0] tb_ent [0:23] = '{28'h41_1_05_01, 28'h36_2_0A_03,
      28'h04_1_05_04, 28'h35_1_0A_05, 28'hC3_3_0A_09, 28'hCD_3_11_0B,
      28'hC9_1_0A_0D, 28'hDB_2_0A_10, 28'hD3_2_0A_11, 28'h31_3_0A_12,
      28'hF5_1_0B_13, 28'hF1_1_0A_14, 28'h32_3_0D_15, 28'h0A_1_07_16,
      28'h13_1_05_17, 28'h39_1_0A_18, 28'hEB_1_04_19, 28'hE3_1_12_1A,
      28'hF9_1_05_1B, 28'hE9_1_05_1C, 28'h37_1_04_1D, 28'hF3_1_04_1F,
      28'h08_1_04_00, 28'h22_3_10_15};
    for (int k = 0; k < 24; k++)
    begin
      feed(tb_ent[k][27:20], int'(tb_ent[k][19:16]));
      `CHK("len", tb_ent[k][17:16], st[9:8])
      `CHK("cycles", tb_ent[k][12:8], st[14:10])
      `CHK("class", tb_ent[k][4:0], st[19:15])
    end
    apb(0, `CID_OFF_OPER, 0);
    `CHK("operand", 16'h5241, rd[15:0])
  endtask

  task automatic t_alu;
    logic [7:0] ax [0:7] = '{8'h9B, 8'h9C, 8'h19, 8'h18, 8'h40, 8'h1B,
      8'h5B, 8'h5A};
    logic [7:0] rx [0:3] = '{8'h03, 8'hC0, 8'h02, 8'h40};
    apb(1, `CID_OFF_OPND, 32'h3C);
    acc_op(8'h78, 1, 8'h00, 5'h00, 8'h3C);
    acc_op(8'h7E, 1, 8'h00, 5'h00, 8'h3C);
    `CHK("mem cyc", 5'h07, st[14:10])
    acc_op(8'h3E, 2, 8'h00, 5'h00, 8'h41);
    acc_op(8'h3C, 1, 8'h7F, 5'h00, 8'h80);
    acc_op(8'h3D, 1, 8'h00, 5'h00, 8'hFF);
    acc_op(8'h2F, 1, 8'h5A, 5'h00, 8'hA5);
    acc_op(8'h27, 1, 8'h0B, 5'h00, 8'h11);
    acc_op(8'hFE, 2, 8'h41, 5'h01, 8'h41);
    apb(0, `CID_OFF_FLAG, 0);
    `CHK("cmp zero", 1'b1, rd[`CID_FLG_ZR])
    `CHK("cmp carry", 1'b0, rd[`CID_FLG_CY])
    for (int o = 0; o < 8; o++)
    begin
      acc_op({2'b11, o[2:0], 3'b110}, 2, 8'h5A, 5'h01, ax[o]);
      feed({2'b10, o[2:0], 3'b110}, 1);
      `CHK("mem op cyc", 5'h07, st[14:10])
      feed({2'b10, o[2:0], 3'b000}, 1);
      `CHK("reg op cyc", 5'h04, st[14:10])
    end
    for (int r = 0; r < 4; r++)
      acc_op({3'b000, r[1:0], 3'b111}, 1, 8'h81, 5'h00, rx[r]);
  endtask

  task t_cond;
    logic t;
    for (int s = 0; s < 2; s++)
    begin
      apb(1, `CID_OFF_FLAG, s ? 32'h1F : 32'h0);
      for (int c = 0; c < 8; c++)
      begin
        t = c[0] == s[0];
        feed({2'b11, c[2:0], 3'b010}, 3);
        `CHK("jump taken", t, st[20])
        feed({2'b11, c[2:0], 3'b100}, 3);
        `CHK("call cyc", t ? 5'h11 : 5'h0B, st[14:10])
        feed({2'b11, c[2:0], 3'b000}, 1);
        `CHK("exit cyc", t ? 5'h0B : 5'h05, st[14:10])
        feed({2'b11, c[2:0], 3'b111}, 1);
        `CHK("restart cls", 5'h0F, st[19:15])
      end
    end
  endtask

  task t_bus;
    apb(0, 12'h020, 0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    `CHK("ready", 1'b1, pready)
    apb(1, `CID_OFF_ACC, 32'h5A);
    pstrb <= 4'h0;
    apb(1, `CID_OFF_ACC, 32'hA5);
    pstrb <= 4'hF;
    apb(0, `CID_OFF_ACC, 0);
    `CHK("strobe off", 32'h5A, rd)
  endtask

  task t_halt;
    feed(8'hFB, 1);
    `CHK("ie on", 1'b1, st[22])
    feed(8'h76, 1);
    `CHK("halted", 1'b1, halted)
    `CHK("halt cyc", 5'h07, st[14:10])
    apb(1, `CID_OFF_BYTE, 32'h3C);
    `CHK("dropped", 1'b0, dn)
    int_req <= 1;
    while (int_ack !== 1'b1)
      @(posedge pclk);
    int_req <= 0;
    `CHK("resumed", 1'b0, halted)
    feed(8'hC7, 1);
    `CHK("ack clear", 1'b0, int_ack)
    `CHK("ie off", 1'b0, st[22])
  endtask

  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    pstrb = 4'hF;
    int_req = 0;
    idx = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `CID_OFF_STAT, 0);
    `CHK("rst len", 2'h1, rd[9:8])
    `CHK("rst cyc", 5'h04, rd[14:10])
    t_table;
    t_alu;
    t_cond;
    t_bus;
    t_halt;
    stop_test;
  end
endmodule // tb
